// File: logic/isodb_top.sv
// Isochronous endpoint double buffering: one OUT and one IN endpoint
// Assumes a packet engine on CLK_SYS delivering decoded token events
// Function
// R1: ISO OUT: no handshake, no endpoint interrupt
// R2: Host drains OUT FIFO at each SOF
// R3: OUT has two FIFOs, swap each SOF
// R4: SOF interrupt even on corrupted SOF
// R5: Stall, NAK, ACK read zero always
// R6: Unread OUT data flushed, flush flag frame
// R7: Missed OUT frame not flagged
// R8: OUT packet error: empty FIFO, error flag
// R9: Host never reads beyond byte count
// R10: OUT overflow clears FIFO, error next SOF
// R11: Endpoint clear empties both FIFOs
// R12: IN token sends whole background FIFO
// R13: Host fills IN FIFO at each SOF
// R14: IN has two FIFOs, swap each SOF
// R15: New background IN FIFO emptied at swap; code empties the old background, which becomes the new foreground
// R16: No handoff bit for ISO IN
// R17: IN sent leaves FIFO empty, flags unchanged
// R18: Missed IN with data flags next frame
// R19: Clear during IN send forces stuff error
// R20: Full IN FIFO writes dropped
// R21: Select bit gates host FIFO access
// R22: Empty flag and count follow selection
// R23: All ISO endpoints swap same cycle
`timescale 1ns/100ps
`include "isodb_map.svh"
module isodb_top
    import isodb_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Endpoint configuration
    input wire logic OUT_IS_ISO,
    input wire logic IN_IS_ISO,
    // Local host access
    input wire logic ENDPOINT_SELECT_REG,
    input wire logic ENDPOINT_ACCESS_SELECT,
    input wire logic ENDPOINT_CLEAR_BIT,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic [7:0] HOST_WDATA,
    output logic [7:0] HOST_RDATA,
    output logic ISO_FIFO_EMPTY,
    output logic [6:0] RX_BYTE_COUNT,
    // Endpoint status
    output logic [2:0] ENDPOINT_STATUS_FLAGS,
    output logic EP_INTERRUPT,
    output logic SOF_INTERRUPT,
    output logic DATA_FLUSH,
    output logic ISO_ERR,
    output logic MISS_IN,
    // USB receive side
    input wire logic SOF_SEEN,
    input wire logic RX_WR,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_END,
    input wire logic RX_BAD,
    // USB transmit side
    input wire logic IN_TOKEN,
    input wire logic TX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    output logic TX_LAST,
    output logic TX_STUFF_ERR
);
    typedef struct packed {
        isodb_tx_state_t tx_state;
        logic rx_err;
        logic frame_err;
        logic rx_clr;
        logic tx_done;
        logic flush;
        logic err;
        logic miss;
        logic sof_irq;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic stuff_err;
    } isodb_top_t;
    isodb_top_t st_reg;
    isodb_top_t st_next;
    logic [1:0] clr_sync;
    logic [1:0] sof_sync;
    logic clr_d;
    logic clr_pulse;
    logic sof;
    logic sof_d;
    logic out_sel;
    logic in_sel;
    logic out_swap;
    logic in_swap;
    logic out_bad;
    logic tx_pop;
    logic tx_take;
    logic [7:0] rx_fg_data;
    logic [7:0] tx_bg_data;
    logic [6:0] rx_fg_cnt;
    logic [6:0] rx_bg_cnt;
    logic [6:0] tx_bg_cnt;
    logic [6:0] tx_fg_cnt;

    // Clear and SOF pins from the outside pass two flops
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            clr_sync <= 2'h0;
            sof_sync <= 2'h0;
            clr_d <= 1'b0;
            sof_d <= 1'b0;
        end else begin
            clr_sync <= {clr_sync[0], ENDPOINT_CLEAR_BIT};
            sof_sync <= {sof_sync[0], SOF_SEEN};
            clr_d <= clr_sync[1];
            sof_d <= sof_sync[1];
        end
    end
    assign clr_pulse = clr_sync[1] & ~clr_d;
    // R4: any SOF edge, valid or not
    assign sof = sof_sync[1] & ~sof_d;
    // R21: access only while selected
    assign out_sel = ENDPOINT_ACCESS_SELECT && ENDPOINT_SELECT_REG == `ISODB_EP_OUT;
    assign in_sel = ENDPOINT_ACCESS_SELECT && ENDPOINT_SELECT_REG == `ISODB_EP_IN;
    // R23: common swap, iso endpoints only
    assign out_swap = sof && OUT_IS_ISO;
    assign in_swap = sof && IN_IS_ISO;
    // R10: overflow counts as a bad packet
    assign out_bad = RX_WR && rx_bg_cnt == 7'h40;
    assign tx_take = st_reg.tx_state == ISODB_TX_SEND && TX_READY && st_reg.tx_valid;
    // Pop on load, so the next byte already sits at the read pointer
    assign tx_pop = (st_reg.tx_state == ISODB_TX_IDLE && IN_TOKEN && IN_IS_ISO)
        || (tx_take && !st_reg.tx_last);

    // R3: OUT pair, USB writes background
    isodb_bank u_out (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .swap(out_swap),
        .clear_all(clr_pulse && ENDPOINT_SELECT_REG == `ISODB_EP_OUT),
        // R6: R8: R10: old foreground, bad packet or overflow emptied
        .clear_bg(st_reg.rx_clr || out_bad || (RX_END && st_reg.rx_err)),
        .bg_wr(RX_WR && !st_reg.rx_err),
        .bg_wdata(RX_DATA),
        .fg_wr(1'b0),
        .fg_wdata(8'h00),
        .bg_rd(1'b0),
        .bg_rdata(),
        .fg_rd(HOST_RD && out_sel),
        .fg_rdata(rx_fg_data),
        .fg_count(rx_fg_cnt),
        .bg_count(rx_bg_cnt)
    );

    // R14: IN pair, host writes foreground
    isodb_bank u_in (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .swap(in_swap),
        // R11: clear empties both halves
        .clear_all(clr_pulse && ENDPOINT_SELECT_REG == `ISODB_EP_IN),
        // R15: old background emptied at swap
        .clear_bg(in_swap),
        .bg_wr(1'b0),
        .bg_wdata(8'h00),
        // R20: full-check inside bank drops writes
        .fg_wr(HOST_WR && in_sel),
        .fg_wdata(HOST_WDATA),
        .bg_rd(tx_pop),
        .bg_rdata(tx_bg_data),
        .fg_rd(1'b0),
        .fg_rdata(),
        .fg_count(tx_fg_cnt),
        .bg_count(tx_bg_cnt)
    );

    always_comb begin
        st_next = st_reg;
        st_next.sof_irq = sof;
        // R6: old foreground emptied a cycle later; bank clears background only
        st_next.rx_clr = out_swap;
        // R8: error marks packet until end, frame until SOF
        if (RX_BAD || out_bad) begin
            st_next.rx_err = 1'b1;
            st_next.frame_err = 1'b1;
        end
        if (RX_END) st_next.rx_err = 1'b0;
        if (sof) begin
            // R6: flag if host left data unread
            st_next.flush = OUT_IS_ISO && rx_fg_cnt != `ISODB_ZERO_CNT;
            // R7: R8: R10: only errors flagged, not silence
            st_next.err = st_reg.frame_err || RX_BAD || out_bad;
            st_next.frame_err = 1'b0;
            st_next.rx_err = 1'b0;
            // R18: data waited, no send completed
            st_next.miss = IN_IS_ISO && !st_reg.tx_done && tx_bg_cnt != `ISODB_ZERO_CNT;
            st_next.tx_done = 1'b0;
        end
        unique case (st_reg.tx_state)
            ISODB_TX_IDLE: begin
                // R12: whole background FIFO sent
                if (IN_TOKEN && IN_IS_ISO) begin
                    st_next.tx_state = ISODB_TX_SEND;
                    st_next.tx_valid = tx_bg_cnt != `ISODB_ZERO_CNT;
                    st_next.tx_data = tx_bg_data;
                    st_next.tx_last = tx_bg_cnt <= 7'h01;
                end
            end
            ISODB_TX_SEND: begin
                // R19: clear mid-send corrupts packet
                if (clr_pulse && ENDPOINT_SELECT_REG == `ISODB_EP_IN) begin
                    st_next.tx_state = ISODB_TX_CORRUPT;
                    st_next.stuff_err = 1'b1;
                    st_next.tx_valid = 1'b0;
                end else if (!st_reg.tx_valid || (tx_take && st_reg.tx_last)) begin
                    // R17: FIFO drained, no flags touched
                    st_next.tx_state = ISODB_TX_IDLE;
                    st_next.tx_valid = 1'b0;
                    st_next.tx_last = 1'b0;
                    st_next.tx_done = 1'b1;
                end else if (tx_take) begin
                    st_next.tx_data = tx_bg_data;
                    st_next.tx_last = tx_bg_cnt <= 7'h01;
                end
            end
            ISODB_TX_CORRUPT: begin
                st_next.tx_state = ISODB_TX_IDLE;
                st_next.stuff_err = 1'b0;
                st_next.tx_last = 1'b0;
            end
            default: st_next.tx_state = ISODB_TX_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Byte at the read pointer shows before its pop; bank data is combinational
    assign HOST_RDATA = out_sel ? rx_fg_data : 8'h00;
    // R22: status of selected OUT foreground
    assign ISO_FIFO_EMPTY = out_sel ? rx_fg_cnt == `ISODB_ZERO_CNT : 1'b1;
    assign RX_BYTE_COUNT = out_sel ? rx_fg_cnt : `ISODB_ZERO_CNT;
    // R5: R16: no handshake bits, no handoff
    assign ENDPOINT_STATUS_FLAGS = 3'h0;
    // R1: endpoint interrupt never used
    assign EP_INTERRUPT = 1'b0;
    assign SOF_INTERRUPT = st_reg.sof_irq;
    assign DATA_FLUSH = st_reg.flush;
    assign ISO_ERR = st_reg.err;
    assign MISS_IN = st_reg.miss;
    assign TX_VALID = st_reg.tx_valid;
    assign TX_DATA = st_reg.tx_data;
    assign TX_LAST = st_reg.tx_last;
    assign TX_STUFF_ERR = st_reg.stuff_err;

    // Steps the properties below start from
    sequence s_frame_bad;
        sof && st_reg.frame_err;
    endsequence
    sequence s_token_go;
        st_reg.tx_state == ISODB_TX_IDLE && IN_TOKEN && IN_IS_ISO && tx_bg_cnt != 7'h00;
    endsequence
    sequence s_last_take;
        tx_take && st_reg.tx_last && !sof;
    endsequence

    // R4: every SOF yields interrupt
    a_sof_irq: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R4
        sof |=> SOF_INTERRUPT)
        else $error("SOF interrupt missing");
    // R5: status zero
    a_status_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
        ENDPOINT_STATUS_FLAGS == 3'h0 && !EP_INTERRUPT)
        else $error("handshake status not zero");
    // R6: flush follows unread data
    a_flush_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
        (sof && OUT_IS_ISO && rx_fg_cnt != 7'h00) |=> DATA_FLUSH)
        else $error("flush flag not raised");
    // R6: flush flag holds in frame
    a_flush_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
        (!sof && DATA_FLUSH) |=> DATA_FLUSH)
        else $error("flush flag dropped mid frame");
    // R8: bad frame errors next frame
    a_err_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
        s_frame_bad |=> ISO_ERR)
        else $error("error flag not raised");
    // R8: error flag holds in frame
    a_err_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
        (!sof && ISO_ERR) |=> ISO_ERR)
        else $error("error flag dropped mid frame");
    // R8: bad packet leaves FIFO empty
    a_bad_empty: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
        (RX_END && st_reg.rx_err && !sof) |=> rx_bg_cnt == 7'h00)
        else $error("bad packet data kept");
    // R10: overflow clears background
    a_ovf_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R10
        (out_bad && !sof) |=> rx_bg_cnt == 7'h00)
        else $error("overflow data kept");
    // R3: USB never fills foreground
    a_fg_stable: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R3
        (!sof && !clr_pulse && !(HOST_RD && out_sel)) |=> $stable(rx_fg_cnt))
        else $error("OUT foreground changed");
    // R11: clear empties OUT side
    a_clear_out: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R11
        (clr_pulse && ENDPOINT_SELECT_REG == 1'b0) |=> (rx_fg_cnt == 7'h00 && rx_bg_cnt == 7'h00))
        else $error("clear left OUT data");
    // R15: old IN background, now foreground, empty after swap
    a_in_swap: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R15
        (in_swap && !clr_pulse) |=> tx_fg_cnt == 7'h00)
        else $error("IN foreground not emptied");
    // R19: clear during send corrupts
    a_stuff_err: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R19
        (st_reg.tx_state == ISODB_TX_SEND && clr_pulse && ENDPOINT_SELECT_REG == 1'b1)
        |=> TX_STUFF_ERR ##1 !TX_STUFF_ERR)
        else $error("stuff error not forced");
    // R18: miss flag after missed IN
    a_miss_in: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R18
        (sof && IN_IS_ISO && !st_reg.tx_done && tx_bg_cnt != 7'h00) |=> MISS_IN)
        else $error("missed IN not flagged");
    // R18: miss flag holds in frame
    a_miss_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R18
        (!sof && MISS_IN) |=> MISS_IN)
        else $error("miss flag dropped mid frame");
    // R12: token loads first byte
    a_tx_token: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R12
        s_token_go |=> TX_VALID && TX_DATA == $past(tx_bg_data))
        else $error("first IN byte wrong");
    // R17: last byte leaves FIFO empty
    a_tx_empty: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R17
        s_last_take |=> !TX_VALID && tx_bg_cnt == 7'h00)
        else $error("IN FIFO not empty after send");
    // R20: full IN FIFO drops writes
    a_in_full: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R20
        (HOST_WR && in_sel && tx_fg_cnt == 7'h40 && !sof && !clr_pulse)
        |=> tx_fg_cnt == 7'h40)
        else $error("write to full FIFO taken");
    // R4: SOF interrupt one cycle
    a_sof_pulse: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R4
        SOF_INTERRUPT |=> !SOF_INTERRUPT)
        else $error("SOF interrupt too long");
    // R21: no access while deselected
    a_sel_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R21
        !ENDPOINT_ACCESS_SELECT |-> HOST_RDATA == 8'h00 && ISO_FIFO_EMPTY)
        else $error("access while deselected");
endmodule

// File: logic/isodb_map.svh
// Offsets-free constant map for the isochronous double buffer block
// Assumes inclusion by bare name from the design files
`ifndef ISODB_MAP_SVH
`define ISODB_MAP_SVH
`define ISODB_FIFO_DEPTH 64
`define ISODB_PTR_W 7
`define ISODB_IDX_W 6
`define ISODB_NUM_EP 2
`define ISODB_EP_W 1
`define ISODB_FRAME_US 1000
`define ISODB_CLK_MHZ 200
`define ISODB_FRAME_CYC (`ISODB_FRAME_US * `ISODB_CLK_MHZ)
`define ISODB_ZERO_CNT 7'h00
`define ISODB_EP_OUT 1'h0
`define ISODB_EP_IN 1'h1
`endif

// File: logic/isodb_pkg.sv
// Types for the isochronous double buffer block
// Assumes the constant map is included alongside
package isodb_pkg;
    typedef enum logic [1:0] {
        ISODB_TX_IDLE = 2'b00,
        ISODB_TX_SEND = 2'b01,
        ISODB_TX_CORRUPT = 2'b10
    } isodb_tx_state_t;
endpackage

// File: logic/isodb_bank.sv
// One double-buffered byte FIFO pair with a swap on start of frame
// Assumes write and read ports never target the same half
`timescale 1ns/100ps
`include "isodb_map.svh"
module isodb_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Swap and clears
    input wire logic swap,
    input wire logic clear_all,
    input wire logic clear_bg,
    // Background write
    input wire logic bg_wr,
    input wire logic [7:0] bg_wdata,
    // Foreground write
    input wire logic fg_wr,
    input wire logic [7:0] fg_wdata,
    // Background read
    input wire logic bg_rd,
    output logic [7:0] bg_rdata,
    // Foreground read
    input wire logic fg_rd,
    output logic [7:0] fg_rdata,
    // Counts
    output logic [`ISODB_PTR_W-1:0] fg_count,
    output logic [`ISODB_PTR_W-1:0] bg_count
);
    logic [7:0] mem0 [`ISODB_FIFO_DEPTH];
    logic [7:0] mem1 [`ISODB_FIFO_DEPTH];
    typedef struct packed {
        logic fg_sel;
        logic [`ISODB_PTR_W-1:0] cnt0;
        logic [`ISODB_PTR_W-1:0] cnt1;
        logic [`ISODB_PTR_W-1:0] rp0;
        logic [`ISODB_PTR_W-1:0] rp1;
    } isodb_bank_t;
    isodb_bank_t st_reg;
    isodb_bank_t st_next;
    logic [`ISODB_PTR_W-1:0] fg_rp;
    logic [`ISODB_PTR_W-1:0] bg_rp;
    logic [`ISODB_PTR_W-1:0] bg_cnt_w;
    logic [`ISODB_PTR_W-1:0] fg_cnt_w;
    assign fg_rp = st_reg.fg_sel ? st_reg.rp1 : st_reg.rp0;
    assign bg_rp = st_reg.fg_sel ? st_reg.rp0 : st_reg.rp1;
    assign fg_cnt_w = st_reg.fg_sel ? st_reg.cnt1 : st_reg.cnt0;
    assign bg_cnt_w = st_reg.fg_sel ? st_reg.cnt0 : st_reg.cnt1;
    assign fg_count = fg_cnt_w - fg_rp;
    assign bg_count = bg_cnt_w - bg_rp;
    assign fg_rdata = st_reg.fg_sel ? mem1[fg_rp[`ISODB_IDX_W-1:0]] : mem0[fg_rp[`ISODB_IDX_W-1:0]];
    assign bg_rdata = st_reg.fg_sel ? mem0[bg_rp[`ISODB_IDX_W-1:0]] : mem1[bg_rp[`ISODB_IDX_W-1:0]];

    always_comb begin
        st_next = st_reg;
        if (fg_rd && fg_count != `ISODB_ZERO_CNT) begin
            if (st_reg.fg_sel) st_next.rp1 = st_reg.rp1 + 7'h01;
            else st_next.rp0 = st_reg.rp0 + 7'h01;
        end
        if (bg_rd && bg_count != `ISODB_ZERO_CNT) begin
            if (st_reg.fg_sel) st_next.rp0 = st_reg.rp0 + 7'h01;
            else st_next.rp1 = st_reg.rp1 + 7'h01;
        end
        if (bg_wr && bg_cnt_w != 7'h40) begin
            if (st_reg.fg_sel) st_next.cnt0 = st_reg.cnt0 + 7'h01;
            else st_next.cnt1 = st_reg.cnt1 + 7'h01;
        end
        if (fg_wr && fg_cnt_w != 7'h40) begin
            if (st_reg.fg_sel) st_next.cnt1 = st_reg.cnt1 + 7'h01;
            else st_next.cnt0 = st_reg.cnt0 + 7'h01;
        end
        if (clear_bg) begin
            if (st_reg.fg_sel) begin
                st_next.cnt0 = `ISODB_ZERO_CNT;
                st_next.rp0 = `ISODB_ZERO_CNT;
            end else begin
                st_next.cnt1 = `ISODB_ZERO_CNT;
                st_next.rp1 = `ISODB_ZERO_CNT;
            end
        end
        if (swap) begin
            st_next.fg_sel = ~st_reg.fg_sel;
        end
        if (clear_all) begin
            st_next.cnt0 = `ISODB_ZERO_CNT;
            st_next.cnt1 = `ISODB_ZERO_CNT;
            st_next.rp0 = `ISODB_ZERO_CNT;
            st_next.rp1 = `ISODB_ZERO_CNT;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Memory has no reset; counts guard all reads
    always_ff @(posedge clk) begin
        if (bg_wr && bg_cnt_w != 7'h40) begin
            if (st_reg.fg_sel) mem0[bg_cnt_w[`ISODB_IDX_W-1:0]] <= bg_wdata;
            else mem1[bg_cnt_w[`ISODB_IDX_W-1:0]] <= bg_wdata;
        end
        if (fg_wr && fg_cnt_w != 7'h40) begin
            if (st_reg.fg_sel) mem1[fg_cnt_w[`ISODB_IDX_W-1:0]] <= fg_wdata;
            else mem0[fg_cnt_w[`ISODB_IDX_W-1:0]] <= fg_wdata;
        end
    end
endmodule

// File: dv/isodb_host_model.sv
// USB host model: frame markers, OUT packets, IN tokens
// Assumes the bench calls its tasks; pins move on falling edges
`timescale 1ns/100ps
module isodb_host_model (
    // Clock
    input wire logic clk,
    // Frame and receive
    output logic sof_seen,
    output logic rx_wr,
    output logic [7:0] rx_data,
    output logic rx_end,
    output logic rx_bad,
    // Transmit and SOF interrupt
    output logic in_token,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_stuff_err,
    input wire logic sof_irq
);
    logic [7:0] got[$];
    logic last_ok, stuff_seen, slow, sof_hit;
    initial begin
        {sof_seen, rx_wr, rx_end, rx_bad, in_token} = 5'h00;
        rx_data = 8'h00;
        tx_ready = 1'b1;
        slow = 1'b0;
    end
    // Slow mode stalls every other beat
    always @(negedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            last_ok <= tx_last;
        end
        if (tx_stuff_err) stuff_seen <= 1'b1;
        if (sof_irq) sof_hit <= 1'b1;
    end
    // Marker held long enough for the two-flop sync
    task automatic sof();
        sof_hit = 1'b0;
        @(negedge clk);
        sof_seen = 1'b1;
        repeat (8) @(negedge clk);
        sof_seen = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Error strobe rides on the last byte
    task automatic out_pkt(input int n, input logic bad);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_wr = 1'b1;
            rx_data = 8'hA0 + 8'(i);
            rx_bad = bad && (i == n - 1);
        end
        @(negedge clk);
        rx_wr = 1'b0;
        rx_bad = 1'b0;
        rx_data = ~rx_data;
        rx_end = 1'b1;
        @(negedge clk);
        rx_end = 1'b0;
    endtask
    task automatic in_pkt();
        int i;
        got.delete();
        i = 0;
        @(negedge clk);
        in_token = 1'b1;
        @(negedge clk);
        in_token = 1'b0;
        @(negedge clk);
        while (tx_valid && i < 400) begin
            @(negedge clk);
            i++;
        end
    endtask
endmodule

// File: dv/isodb_tb_top.sv
// Self-checking bench for the isochronous double buffer
// Assumes the host model drives the USB side of the block
`timescale 1ns/100ps
module isodb_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, sel_ep = 1'b0, acc = 1'b0, clr = 1'b0;
    logic rd = 1'b0, wr = 1'b0, empty, ep_irq, sof_irq, flush, err, miss;
    logic [7:0] wdata = 8'h00, rdata, tx_data, rx_data;
    logic [6:0] cnt;
    logic [2:0] stat;
    logic sof_seen, rx_wr, rx_end, rx_bad, in_tok, tx_rdy, tx_valid, tx_last, stuff;
    int err_count = 0, compares = 0;
    always #2.5 clk = ~clk;
    isodb_top i_dut (.CLK_SYS(clk), .RST_N(rst_n), .OUT_IS_ISO(1'b1), .IN_IS_ISO(1'b1),
        .ENDPOINT_SELECT_REG(sel_ep), .ENDPOINT_ACCESS_SELECT(acc),
        .ENDPOINT_CLEAR_BIT(clr), .HOST_RD(rd), .HOST_WR(wr), .HOST_WDATA(wdata),
        .HOST_RDATA(rdata), .ISO_FIFO_EMPTY(empty), .RX_BYTE_COUNT(cnt),
        .ENDPOINT_STATUS_FLAGS(stat), .EP_INTERRUPT(ep_irq), .SOF_INTERRUPT(sof_irq),
        .DATA_FLUSH(flush), .ISO_ERR(err), .MISS_IN(miss), .SOF_SEEN(sof_seen),
        .RX_WR(rx_wr), .RX_DATA(rx_data), .RX_END(rx_end), .RX_BAD(rx_bad),
        .IN_TOKEN(in_tok), .TX_READY(tx_rdy), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_LAST(tx_last), .TX_STUFF_ERR(stuff));
    isodb_host_model i_host (.clk(clk), .sof_seen(sof_seen), .rx_wr(rx_wr),
        .rx_data(rx_data), .rx_end(rx_end), .rx_bad(rx_bad), .in_token(in_tok),
        .tx_ready(tx_rdy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_stuff_err(stuff), .sof_irq(sof_irq));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [7:0] flagv();
        return {5'h00, flush, err, miss};
    endfunction
    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic sel(input logic ep);
        @(negedge clk);
        sel_ep = ep;
        acc = 1'b1;
        @(negedge clk);
    endtask
    task automatic unsel();
        @(negedge clk);
        acc = 1'b0;
    endtask
    task automatic frame();
        i_host.sof();
        chk("sof_irq", 8'(i_host.sof_hit), 8'h01);
    endtask
    task automatic clear();
        @(negedge clk);
        clr = 1'b1;
        repeat (4) @(negedge clk);
        clr = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic fill(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            wr = 1'b1;
            wdata = base + 8'(i);
        end
        @(negedge clk);
        wr = 1'b0;
    endtask
    // Reads stop at the reported count
    task automatic drain(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            chk("rdata", rdata, 8'hA0 + 8'(i));
            rd = 1'b1;
        end
        @(negedge clk);
        rd = 1'b0;
    endtask
    task automatic t_out();
        i_host.out_pkt(3, 1'b0);
        sel(1'b0);
        chk("count", 8'(cnt), 8'h00);
        unsel();
        frame();
        chk("count", 8'(cnt), 8'h00);
        sel(1'b0);
        chk("count", 8'(cnt), 8'h03);
        chk("empty", 8'(empty), 8'h00);
        drain(3);
        chk("empty", 8'(empty), 8'h01);
        chk("status", {5'h00, stat}, 8'h00);
        chk("ep_irq", 8'(ep_irq), 8'h00);
        unsel();
        frame();
        chk("flags", flagv(), 8'h00);
        $display("t_out done");
    endtask
    task automatic t_flush();
        i_host.out_pkt(2, 1'b0);
        frame();
        frame();
        chk("flags", flagv(), 8'h04);
        sel(1'b0);
        chk("empty", 8'(empty), 8'h01);
        unsel();
        $display("t_flush done");
    endtask
    task automatic t_err();
        i_host.out_pkt(4, 1'b1);
        frame();
        chk("flags", flagv(), 8'h02);
        sel(1'b0);
        chk("count", 8'(cnt), 8'h00);
        unsel();
        i_host.out_pkt(65, 1'b0);
        frame();
        chk("flags", flagv(), 8'h02);
        sel(1'b0);
        chk("count", 8'(cnt), 8'h00);
        unsel();
        frame();
        chk("flags", flagv(), 8'h00);
        $display("t_err done");
    endtask
    task automatic t_clear();
        i_host.out_pkt(5, 1'b0);
        frame();
        i_host.out_pkt(2, 1'b0);
        sel(1'b0);
        chk("count", 8'(cnt), 8'h05);
        clear();
        chk("count", 8'(cnt), 8'h00);
        unsel();
        frame();
        chk("flags", flagv(), 8'h00);
        sel(1'b0);
        chk("count", 8'(cnt), 8'h00);
        unsel();
        $display("t_clear done");
    endtask
    task automatic t_in(input int n, input logic slow);
        int k;
        k = (n > 64) ? 64 : n;
        sel(1'b1);
        fill(n, 8'h50);
        unsel();
        frame();
        i_host.slow = slow;
        i_host.in_pkt();
        chk("tx_len", 8'(i_host.got.size()), 8'(k));
        for (int i = 0; i < k; i++) begin
            chk("tx_data", i_host.got[i], 8'h50 + 8'(i));
        end
        chk("tx_last", 8'(i_host.last_ok), 8'h01);
        chk("status", {4'h0, ep_irq, stat}, 8'h00);
        i_host.in_pkt();
        chk("tx_len", 8'(i_host.got.size()), 8'h00);
        i_host.slow = 1'b0;
        frame();
        chk("flags", flagv(), 8'h00);
        $display("t_in done");
    endtask
    task automatic t_miss();
        sel(1'b1);
        fill(3, 8'h30);
        unsel();
        frame();
        frame();
        chk("flags", flagv(), 8'h01);
        sel(1'b1);
        fill(2, 8'h70);
        unsel();
        frame();
        i_host.in_pkt();
        chk("tx_len", 8'(i_host.got.size()), 8'h02);
        chk("tx_data", i_host.got[0], 8'h70);
        $display("t_miss done");
    endtask
    task automatic t_abort();
        sel(1'b1);
        fill(64, 8'h00);
        unsel();
        frame();
        i_host.stuff_seen = 1'b0;
        i_host.slow = 1'b1;
        fork
            i_host.in_pkt();
            begin
                repeat (10) @(negedge clk);
                clear();
            end
        join
        chk("stuff", 8'(i_host.stuff_seen), 8'h01);
        i_host.slow = 1'b0;
        $display("t_abort done");
    endtask
    // Whole run is under a thousand cycles
    initial begin
        #200000;
        err_count++;
        $display("ERROR watchdog expected finish seen hang");
        complete_run();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_out();
        t_flush();
        t_err();
        t_clear();
        t_in(3, 1'b0);
        t_in(65, 1'b1);
        t_miss();
        t_abort();
        complete_run();
    end
endmodule
